/* File: core/ptls_defines.svh */
// Register offsets, field positions, reset values for the port line status bank.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef PTLS_DEFINES_SVH
`define PTLS_DEFINES_SVH
`define PTLS_OFF_TXADV1     3'h2
`define PTLS_OFF_TXADV0     3'h3
`define PTLS_OFF_LINEMODE   3'h4
`define PTLS_OFF_STATUS     3'h5
`define PTLS_OFF_TEST6      3'h6
`define PTLS_OFF_TEST7      3'h7
`define PTLS_RST_TXADV1     8'h00
`define PTLS_RST_TXADV0     8'ha8
`define PTLS_RST_LINEMODE   8'h80
`define PTLS_BIT_EQ         0
`define PTLS_BIT_LOOP       0
`define PTLS_BIT_COAX       7
`define PTLS_BIT_RX_SIGNAL_LOST      4
`define PTLS_BIT_RX_LOCK_LOST      3
`define PTLS_BIT_TX_LOCK_LOST      1
`define PTLS_BIT_TX_FIFO_ERROR       0
`define PTLS_BOOST_NORMAL   2'h0
`define PTLS_BOOST_FIVE     2'h1
`define PTLS_BOOST_TEST_RESERVED     2'h2
`define PTLS_BOOST_TEN      2'h3
`endif

/* File: core/ptls_pkg.sv */
// Types shared by the port line status bank.
// Assumes the defines header is on the include path.
package ptls_pkg;
   typedef enum logic [1:0] {
      PTLS_AMP_NORMAL = 2'b00,
      PTLS_AMP_FIVE   = 2'b01,
      PTLS_AMP_TEST_RESERVED   = 2'b10,
      PTLS_AMP_TEN    = 2'b11
   } ptls_amp_t;
   typedef struct packed {
      logic [7:0] txAdv1;
      logic [7:0] txAdv0;
      logic [7:0] lineMode;
      logic [3:0] alarm;     // rx_signal_lost, rx_lock_lost, tx_lock_lost, fifoErr
      logic       fifoRstQ;
   } ptls_state_t;
endpackage

/* File: core/port_tx_line_status_regs.sv */
// Per-port transmit/line control and alarm status register bank.
// Assumes a serial control port front end delivering one-cycle rd/wr strobes.
`timescale 1ns/1ps
`default_nettype none
`include "ptls_defines.svh"
module port_tx_line_status_regs
   import ptls_pkg::*;
#(
   parameter int REG_W = 8
)
(
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic [2:0] regAddr,
   input  wire logic       regWr,
   input  wire logic       regRd,
   input  wire logic [7:0] regWdata,
   output logic      [7:0] regRdata,
   input  wire logic       fifoPtrResetIn,
   input  wire logic       rxAlarmOverride,
   input  wire logic       rxSignalLostIn,
   input  wire logic       rxLockLostIn,
   input  wire logic       txLockLostIn,
   input  wire logic       txFifoErrorIn,
   output logic            txInputEqualizerEnable,
   output logic      [1:0] txAmplitudeBoost,
   output logic            fullDigitalLoopback,
   output logic            coaxLineSelect,
   output logic            coaxCodecEnable,
   output logic            coaxDriverEnable,
   output logic            opticalTxEnable,
   output logic            txFifoPointerReset,
   output logic            rxDetectCounterReset
);
   ptls_state_t st_r;
   ptls_state_t st_nxt;
   logic [3:0]  evt;
   logic        rdStatus;

   // Refuse widths the fixed eight-bit register map cannot serve
   if (REG_W != 8) begin : g_badWidth
      $error("register width must be 8");
   end

   // Register index match, shared by the read-clear decode and the checks
   function automatic logic hitIdx(input logic [2:0] a, input logic [2:0] idx);
      return a == idx;
   endfunction

   // Live alarm events, receive ones masked by override
   always_comb begin
      evt[3] = rxSignalLostIn & ~rxAlarmOverride;
      evt[2] = rxLockLostIn & ~rxAlarmOverride;
      evt[1] = txLockLostIn;
      evt[0] = txFifoErrorIn;
      rdStatus = regRd && hitIdx(regAddr, `PTLS_OFF_STATUS);
   end

   // Next state: writes, sticky alarms, read clear
   always_comb begin
      st_nxt = st_r;
      st_nxt.fifoRstQ = fifoPtrResetIn;
      if (regWr) begin
         case (regAddr)
            `PTLS_OFF_TXADV1:   st_nxt.txAdv1 = regWdata;
            `PTLS_OFF_TXADV0:   st_nxt.txAdv0 = regWdata;
            `PTLS_OFF_LINEMODE: st_nxt.lineMode = regWdata;
            default:            st_nxt.txAdv1 = st_r.txAdv1;
         endcase
      end
      if (rdStatus) begin
         st_nxt.alarm = 4'h0;
      end
      st_nxt.alarm = st_nxt.alarm | evt;
      if (rxAlarmOverride) begin
         st_nxt.alarm[3:2] = 2'h0;
      end
      if (fifoPtrResetIn) begin
         st_nxt.alarm[0] = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{`PTLS_RST_TXADV1, `PTLS_RST_TXADV0, `PTLS_RST_LINEMODE, 4'h0, 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Read mux, status bits in their positions
   always_comb begin
      case (regAddr)
         `PTLS_OFF_TXADV1:   regRdata = st_r.txAdv1;
         `PTLS_OFF_TXADV0:   regRdata = st_r.txAdv0;
         `PTLS_OFF_LINEMODE: regRdata = st_r.lineMode;
         `PTLS_OFF_STATUS:   regRdata = {3'h0, st_r.alarm[3:2], 1'b0, st_r.alarm[1:0]};
         default:            regRdata = 8'h00;
      endcase
   end

   // Control outputs to analog and datapath
   assign txInputEqualizerEnable = st_r.txAdv1[`PTLS_BIT_EQ];
   assign txAmplitudeBoost       = st_r.txAdv0[2:1];
   assign fullDigitalLoopback    = st_r.txAdv0[`PTLS_BIT_LOOP];
   assign coaxLineSelect         = st_r.lineMode[`PTLS_BIT_COAX];
   assign coaxCodecEnable        = st_r.lineMode[`PTLS_BIT_COAX];
   assign coaxDriverEnable       = st_r.lineMode[`PTLS_BIT_COAX];
   assign opticalTxEnable        = ~st_r.lineMode[`PTLS_BIT_COAX];
   assign txFifoPointerReset     = st_r.fifoRstQ;
   assign rxDetectCounterReset   = rxAlarmOverride;

   property p_ferrClear;
      @(posedge mclk) disable iff (!rst_b)
      fifoPtrResetIn |=> !st_r.alarm[0];
   endproperty
   a_ferrClear: assert property (p_ferrClear) else $error("fifo error not cleared");
   property p_ferrSet;
      @(posedge mclk) disable iff (!rst_b)
      (txFifoErrorIn && !fifoPtrResetIn) |=> st_r.alarm[0];
   endproperty
   a_ferrSet: assert property (p_ferrSet) else $error("fifo error not latched");
   property p_override;
      @(posedge mclk) disable iff (!rst_b)
      rxAlarmOverride |=> (st_r.alarm[3:2] == 2'h0);
   endproperty
   a_override: assert property (p_override) else $error("override left rx alarm");
   property p_losSet;
      @(posedge mclk) disable iff (!rst_b)
      (rxSignalLostIn && !rxAlarmOverride) |=> st_r.alarm[3];
   endproperty
   a_losSet: assert property (p_losSet) else $error("los not latched");
   property p_lolSet;
      @(posedge mclk) disable iff (!rst_b)
      (rxLockLostIn && !rxAlarmOverride) |=> st_r.alarm[2];
   endproperty
   a_lolSet: assert property (p_lolSet) else $error("rx lol not latched");
   property p_txlolSet;
      @(posedge mclk) disable iff (!rst_b)
      txLockLostIn |=> st_r.alarm[1];
   endproperty
   a_txlolSet: assert property (p_txlolSet) else $error("tx lol not latched");
   property p_readClear;
      @(posedge mclk) disable iff (!rst_b)
      (rdStatus && !txLockLostIn) |=> !st_r.alarm[1];
   endproperty
   a_readClear: assert property (p_readClear) else $error("read did not clear");
   property p_modeExcl;
      @(posedge mclk) disable iff (!rst_b)
      (coaxDriverEnable != opticalTxEnable) && (coaxCodecEnable == coaxLineSelect);
   endproperty
   a_modeExcl: assert property (p_modeExcl) else $error("line mode overlap");
   property p_eqWrite;
      @(posedge mclk) disable iff (!rst_b)
      (regWr && regAddr == `PTLS_OFF_TXADV1) |=> (txInputEqualizerEnable == $past(regWdata[0]));
   endproperty
   a_eqWrite: assert property (p_eqWrite) else $error("equalizer bit not taken");
   property p_loopWrite;
      @(posedge mclk) disable iff (!rst_b)
      (regWr && regAddr == `PTLS_OFF_TXADV0) |=>
         (fullDigitalLoopback == $past(regWdata[0])) && (txAmplitudeBoost == $past(regWdata[2:1]));
   endproperty
   a_loopWrite: assert property (p_loopWrite) else $error("adv0 write not taken");
   property p_fifoRst;
      @(posedge mclk) disable iff (!rst_b)
      fifoPtrResetIn |=> txFifoPointerReset;
   endproperty
   a_fifoRst: assert property (p_fifoRst) else $error("pointer reset missing");

   // Line select bit must follow a write to the mode register
   property p_coaxSel;
      @(posedge mclk) disable iff (!rst_b)
      (regWr && hitIdx(regAddr, `PTLS_OFF_LINEMODE)) |=> (coaxLineSelect == $past(regWdata[7]));
   endproperty
   a_coaxSel: assert property (p_coaxSel) else $error("line select not taken");

   // Read clear of each alarm when its cause has gone
   property p_losReadClear;
      @(posedge mclk) disable iff (!rst_b)
      (rdStatus && !rxSignalLostIn) |=> !st_r.alarm[3];
   endproperty
   a_losReadClear: assert property (p_losReadClear) else $error("los kept after read");

   property p_lolReadClear;
      @(posedge mclk) disable iff (!rst_b)
      (rdStatus && !rxLockLostIn) |=> !st_r.alarm[2];
   endproperty
   a_lolReadClear: assert property (p_lolReadClear) else $error("rx lol kept after read");

   property p_ferrReadClear;
      @(posedge mclk) disable iff (!rst_b)
      (rdStatus && !txFifoErrorIn) |=> !st_r.alarm[0];
   endproperty
   a_ferrReadClear: assert property (p_ferrReadClear) else $error("fifo error kept");

   // Status bits sit at their fixed positions, unused ones read zero
   property p_statusMap;
      @(posedge mclk) disable iff (!rst_b)
      hitIdx(regAddr, `PTLS_OFF_STATUS) |->
         (regRdata == {3'h0, st_r.alarm[3:2], 1'b0, st_r.alarm[1:0]});
   endproperty
   a_statusMap: assert property (p_statusMap) else $error("status bit map wrong");

   // Override keeps the detection counters in reset
   property p_cntRst;
      @(posedge mclk) disable iff (!rst_b)
      rxAlarmOverride |-> rxDetectCounterReset;
   endproperty
   a_cntRst: assert property (p_cntRst) else $error("counter reset missing");
endmodule
`default_nettype wire

/* File: tb/port_tx_line_status_regs_tb.sv */
// Self-checking bench for the port line status register bank.
// Assumes design and package compiled first; inputs change at falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "ptls_defines.svh"
module port_tx_line_status_regs_tb
   import ptls_pkg::*;
;
   logic       mclk, rst_b, regWr, regRd, fifoPtrResetIn, rxAlarmOverride;
   logic       rxSignalLostIn, rxLockLostIn, txLockLostIn, txFifoErrorIn;
   logic [2:0] regAddr;
   logic [7:0] regWdata, regRdata;
   logic [1:0] txAmplitudeBoost;
   logic       txInputEqualizerEnable, fullDigitalLoopback, coaxLineSelect;
   logic       coaxCodecEnable, coaxDriverEnable, opticalTxEnable;
   logic       txFifoPointerReset, rxDetectCounterReset;
   int         n_errors = 0;
   int         total_checks = 0;
   port_tx_line_status_regs dut (.mclk, .rst_b, .regAddr, .regWr, .regRd, .regWdata,
      .regRdata, .fifoPtrResetIn, .rxAlarmOverride, .rxSignalLostIn, .rxLockLostIn,
      .txLockLostIn, .txFifoErrorIn, .txInputEqualizerEnable, .txAmplitudeBoost,
      .fullDigitalLoopback, .coaxLineSelect, .coaxCodecEnable, .coaxDriverEnable,
      .opticalTxEnable, .txFifoPointerReset, .rxDetectCounterReset);
   // Clock at 100 MHz
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle write strobe
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      regWdata = d;
      regWr = 1'b1;
      @(negedge mclk);
      regWr = 1'b0;
   endtask
   // Read with one-cycle strobe, data judged before the taking edge
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(negedge mclk);
      regAddr = a;
      regRd = 1'b1;
      #1 chk(regRdata, e);
      @(negedge mclk);
      regRd = 1'b0;
   endtask
   function automatic logic [7:0] lineOuts();
      return {4'h0, coaxLineSelect, coaxCodecEnable, coaxDriverEnable, opticalTxEnable};
   endfunction
   task automatic t_reset();
      rd(`PTLS_OFF_TXADV1, `PTLS_RST_TXADV1);
      rd(`PTLS_OFF_TXADV0, `PTLS_RST_TXADV0);
      rd(`PTLS_OFF_LINEMODE, `PTLS_RST_LINEMODE);
      chk(lineOuts(), 8'h0e);
      rd(`PTLS_OFF_STATUS, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_ctrl();
      wr(3'h2, 8'h01);
      chk({7'h0, txInputEqualizerEnable}, 8'h01);
      for (int b = 0; b < 4; b++) begin
         if (b == 2) continue;
         wr(3'h3, {5'h15, 2'(b), 1'b1});
         chk({6'h0, txAmplitudeBoost}, 8'(b));
         chk({7'h0, fullDigitalLoopback}, 8'h01);
      end
      wr(3'h3, 8'ha8);
      chk({7'h0, fullDigitalLoopback}, 8'h00);
      wr(3'h2, 8'h00);
      chk({7'h0, txInputEqualizerEnable}, 8'h00);
      wr(3'h4, 8'h00);
      chk(lineOuts(), 8'h01);
      rd(3'h4, 8'h00);
      wr(3'h4, 8'h80);
      chk(lineOuts(), 8'h0e);
      $display("test control done");
   endtask
   task automatic t_alarm();
      @(negedge mclk);
      {rxSignalLostIn, rxLockLostIn, txLockLostIn, txFifoErrorIn} = 4'hf;
      @(negedge mclk);
      {rxSignalLostIn, rxLockLostIn, txLockLostIn, txFifoErrorIn} = 4'h0;
      rd(3'h5, 8'h1b);
      rd(3'h5, 8'h00);
      txLockLostIn = 1'b1;
      rd(3'h5, 8'h02);
      rd(3'h5, 8'h02);
      txLockLostIn = 1'b0;
      rd(3'h5, 8'h02);
      rd(3'h5, 8'h00);
      $display("test alarm done");
   endtask
   task automatic t_fifo();
      @(negedge mclk);
      txFifoErrorIn = 1'b1;
      fifoPtrResetIn = 1'b1;
      @(negedge mclk);
      chk({7'h0, txFifoPointerReset}, 8'h01);
      rd(3'h5, 8'h00);
      txFifoErrorIn = 1'b0;
      fifoPtrResetIn = 1'b0;
      @(negedge mclk);
      chk({7'h0, txFifoPointerReset}, 8'h00);
      $display("test fifo done");
   endtask
   task automatic t_override();
      @(negedge mclk);
      rxAlarmOverride = 1'b1;
      {rxSignalLostIn, rxLockLostIn} = 2'h3;
      #1 chk({7'h0, rxDetectCounterReset}, 8'h01);
      rd(3'h5, 8'h00);
      {rxSignalLostIn, rxLockLostIn, rxAlarmOverride} = 3'h0;
      #1 chk({7'h0, rxDetectCounterReset}, 8'h00);
      $display("test override done");
   endtask
   task automatic t_refused();
      for (int a = 5; a < 9; a++) wr(3'(a), 8'hff);
      for (int a = 5; a < 9; a++) rd(3'(a), 8'h00);
      rd(3'h4, 8'h80);
      $display("test refused done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog, far beyond the fewer than a hundred cycles the tests take
   initial begin
      #50000;
      n_errors++;
      results();
   end
   // Main sequence
   initial begin
      {rst_b, regWr, regRd, fifoPtrResetIn, rxAlarmOverride} = 5'h0;
      {rxSignalLostIn, rxLockLostIn, txLockLostIn, txFifoErrorIn} = 4'h0;
      regAddr = 3'h0;
      regWdata = 8'h00;
      repeat (6) @(negedge mclk);
      rst_b = 1'b1;
      t_reset();
      t_ctrl();
      t_alarm();
      t_fifo();
      t_override();
      t_refused();
      results();
   end
endmodule
`default_nettype wire
